//--- design/status_priv_pkg.sv
package status_priv_pkg;

  // Privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // Register width encodings, shared by all three width fields
  localparam logic [1:0] WIDTH_NONE = 2'h0;
  localparam logic [1:0] WIDTH_32 = 2'h1;
  localparam logic [1:0] WIDTH_64 = 2'h2;

  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_MWIDTH = 12'h004;
  localparam logic [11:0] OFF_STATE = 12'h008;

  // Control register field positions
  localparam int POS_MIE = 0;
  localparam int POS_MPIE = 1;
  localparam int POS_PREV = 2;
  localparam int POS_OVR = 4;
  localparam int POS_EXR = 5;
  localparam int POS_SUA = 6;
  localparam int POS_TRAPVM = 7;
  localparam int POS_WAITTRAP = 8;
  localparam int POS_TRAPRET = 9;
  localparam int POS_SW = 10;
  localparam int POS_UW = 12;

  // State register field positions
  localparam int POS_DPRIV = 0;
  localparam int POS_DWIDTH = 2;
  localparam int POS_WFIBUSY = 4;

  // Values after reset
  localparam logic [1:0] RST_PREV = 2'h3;
  localparam logic [1:0] RST_WIDTH = 2'h2;

  // Timing: clock period and the bound on a trapped wait
  localparam int CLK_PERIOD_NS = 100;
  localparam int WFI_LIMIT_NS = 1000;
  // Longest time, so it rounds down; never below one cycle
  localparam int WFI_CYCLES = (WFI_LIMIT_NS / CLK_PERIOD_NS) < 1 ? 1 :
                              (WFI_LIMIT_NS / CLK_PERIOD_NS);
  localparam int WFI_CNT_W = 8;
  localparam logic [7:0] WFI_LAST = 8'(WFI_CYCLES - 1);

endpackage

//--- design/width_legalize.sv
`timescale 1ns/1ps
`default_nettype none
// Legal value for one write-any-read-legal width field
module width_legalize
  import status_priv_pkg::*;
(
  input wire logic [1:0] wrVal, // Value software wrote
  input wire logic [1:0] oldVal, // Value held before the write
  input wire logic present, // Mode exists on a wide base
  input wire logic fixed, // Field follows a forced value
  input wire logic [1:0] fixedVal, // Forced value when fixed
  output logic [1:0] legal // Value to keep
);

  // Absent reads zero, fixed follows, unsupported code keeps old value
  always_comb begin
    if (!present) begin
      legal = WIDTH_NONE;
    end else if (fixed) begin
      legal = fixedVal;
    end else if (wrVal == WIDTH_32 || wrVal == WIDTH_64) begin
      legal = wrVal;
    end else begin
      legal = oldVal;
    end
  end

endmodule // width_legalize
`default_nettype wire

//--- design/width_adjust.sv
`timescale 1ns/1ps
`default_nettype none
// Narrows a value to the configured width and sign-extends it
module width_adjust
  import status_priv_pkg::*;
#(
  parameter int XW = 64 // Widest supported width
) (
  input wire logic [XW-1:0] valueIn, // Full-width value
  input wire logic [1:0] widthCode, // Configured width
  output logic [XW-1:0] valueOut // Narrowed and extended value
);

  // At 32 bits, upper bits are ignored and refilled from bit 31
  always_comb begin
    if (widthCode == WIDTH_32) begin
      valueOut = {{(XW-32){valueIn[31]}}, valueIn[31:0]};
    end else begin
      valueOut = valueIn;
    end
  end

endmodule // width_adjust
`default_nettype wire

//--- design/status_privilege_controls.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module status_privilege_controls
  import status_priv_pkg::*;
#(
  parameter bit HAS_S = 1'b1, // Supervisor mode implemented
  parameter bit HAS_U = 1'b1, // User mode implemented
  parameter bit BASE64 = 1'b1, // Wide base
  parameter bit S_FIXED = 1'b0, // Supervisor width forced to machine
  parameter bit U_FIXED = 1'b0 // User width forced to machine
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] curPriv, // Current privilege
  input wire logic satpAccess, // Translation control access decoded
  input wire logic fenceVma, // Translation fence decoded
  input wire logic sretInsn, // Supervisor return decoded
  input wire logic wfiStart, // Wait issued, one-cycle pulse
  input wire logic wfiWake, // Wait completed
  input wire logic trapTake, // Trap into machine mode, pulse
  input wire logic [1:0] trapFromPriv, // Mode the trap came from
  input wire logic pageTranslate, // Page translation in effect
  input wire logic dataLoad, // Data access is a load
  input wire logic pteRead, // Page readable
  input wire logic pteExec, // Page executable
  input wire logic pteUser, // Page user accessible
  input wire logic physFault, // Attribute or protection fault
  input wire logic [63:0] srcA, // Source operand A
  input wire logic [63:0] srcB, // Source operand B
  input wire logic [63:0] rawResult, // Unadjusted result
  input wire logic [63:0] rawAddr, // Data address before translation
  output logic [63:0] opA, // Operand A at execution width
  output logic [63:0] opB, // Operand B at execution width
  output logic [63:0] result, // Result extended to full width
  output logic [63:0] dataAddr, // Data address at data width
  output logic [1:0] dataPriv, // Privilege for loads and stores
  output logic [1:0] dataWidth, // Width for load and store addresses
  output logic [1:0] execWidth, // Width of the current mode
  output logic illegalInsn, // Illegal instruction exception
  output logic pageFault, // Page permission fault
  output logic accessFault // Physical access fault
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic mie; // Machine interrupt enable
    logic mpie; // Prior enable
    logic [1:0] prevPriv; // Previous privilege field
    logic ovr; // Privilege override bit
    logic exr; // Execute-readable bit
    logic sua; // Supervisor user access bit
    logic trapVm; // Trap virtual memory bit
    logic waitTrap; // Timeout wait bit
    logic trapRet; // Trap supervisor return bit
    logic [1:0] sWidth; // Supervisor width field
    logic [1:0] uWidth; // User width field
    logic [1:0] mWidth; // Machine width field
    logic wfiBusy; // Timed wait running
    logic [WFI_CNT_W-1:0] wfiCount; // Cycles waited
    logic wfiIllegal; // Wait timed out, one cycle
    logic [31:0] rdata; // Read data
  } state_t;

  state_t st_q; // Registered state
  state_t st_d; // Next state
  logic [1:0] sLegal; // Legalised supervisor width
  logic [1:0] uLegal; // Legalised user width
  logic [1:0] sNew; // Supervisor width written this cycle
  logic [1:0] uNew; // User width written this cycle
  logic wrAccess; // Write takes effect
  logic setupRead; // Read setup phase
  logic mapped; // Address decodes
  logic wfiTimed; // Wait would be timed
  logic [31:0] ctrlView; // Control register as read
  logic [1:0] sEff; // Effective supervisor width
  logic [1:0] uEff; // Effective user width

  // Legal previous privilege: only implemented modes
  function automatic logic [1:0] legalPriv(input logic [1:0] p,
                                           input logic [1:0] old);
    logic [1:0] r;
    r = old;
    if (p == PRIV_M) begin
      r = PRIV_M;
    end else if (p == PRIV_S && HAS_S) begin
      r = PRIV_S;
    end else if (p == PRIV_U && HAS_U) begin
      r = PRIV_U;
    end
    return r;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  // Zero wait states: access phase always completes
  assign pready = 1'b1;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_MWIDTH) ||
                  (paddr == OFF_STATE);
  assign wrAccess = psel && penable && pwrite;
  assign setupRead = psel && !penable && !pwrite;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_q.rdata;

  // ****************************************
  // Width fields
  // ****************************************
  // keep legal encoding
  width_legalize u_sLegal (
    .wrVal(pwdata[POS_SW+:2]),
    .oldVal(st_q.sWidth),
    .present(BASE64 && HAS_S),
    .fixed(S_FIXED),
    .fixedVal(st_q.mWidth),
    .legal(sLegal)
  );

  width_legalize u_uLegal (
    .wrVal(pwdata[POS_UW+:2]),
    .oldVal(st_q.uWidth),
    .present(BASE64 && HAS_U),
    .fixed(U_FIXED),
    .fixedVal(st_q.mWidth),
    .legal(uLegal)
  );

  // narrow base runs lower modes at 32
  assign sEff = BASE64 ? st_q.sWidth : WIDTH_32;
  assign uEff = BASE64 ? st_q.uWidth : WIDTH_32;

  // Control register as software sees it; absent bits read zero
  always_comb begin
    ctrlView = '0;
    ctrlView[POS_MIE] = st_q.mie;
    ctrlView[POS_MPIE] = st_q.mpie;
    ctrlView[POS_PREV+:2] = st_q.prevPriv;
    ctrlView[POS_OVR] = st_q.ovr;
    ctrlView[POS_EXR] = st_q.exr;
    ctrlView[POS_SUA] = st_q.sua;
    ctrlView[POS_TRAPVM] = st_q.trapVm;
    ctrlView[POS_WAITTRAP] = st_q.waitTrap;
    ctrlView[POS_TRAPRET] = st_q.trapRet;
    ctrlView[POS_SW+:2] = st_q.sWidth;
    ctrlView[POS_UW+:2] = st_q.uWidth;
  end

  // user wait is timed whenever supervisor exists
  // timed below machine when bit set
  assign wfiTimed = (curPriv != PRIV_M) &&
                    (st_q.waitTrap || (HAS_S && curPriv == PRIV_U));

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.wfiIllegal = 1'b0;
    sNew = st_q.sWidth;
    uNew = st_q.uWidth;
    // Capture read data in the setup phase
    if (setupRead) begin
      unique case (paddr)
        OFF_CTRL: st_d.rdata = ctrlView;
        OFF_MWIDTH: st_d.rdata = {30'h0, st_q.mWidth};
        OFF_STATE: begin
          st_d.rdata = '0;
          st_d.rdata[POS_DPRIV+:2] = dataPriv;
          st_d.rdata[POS_DWIDTH+:2] = dataWidth;
          st_d.rdata[POS_WFIBUSY] = st_q.wfiBusy;
        end
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    // Control register write
    if (wrAccess && paddr == OFF_CTRL) begin
      st_d.mie = pwdata[POS_MIE];
      st_d.mpie = pwdata[POS_MPIE];
      st_d.prevPriv = legalPriv(pwdata[POS_PREV+:2], st_q.prevPriv);
      st_d.ovr = HAS_U && pwdata[POS_OVR];
      st_d.exr = HAS_S && pwdata[POS_EXR];
      st_d.sua = HAS_S && pwdata[POS_SUA];
      st_d.trapVm = HAS_S && pwdata[POS_TRAPVM];
      // wait trap needs a lower mode
      st_d.waitTrap = (HAS_S || HAS_U) && pwdata[POS_WAITTRAP];
      st_d.trapRet = HAS_S && pwdata[POS_TRAPRET];
      // supervisor field present only with the mode
      // user field present only with the mode
      sNew = sLegal;
      uNew = uLegal;
      // no ordering check between widths, on purpose
    end
    // Machine width write; narrow base keeps it at 32
    if (wrAccess && paddr == OFF_MWIDTH && BASE64) begin
      if (pwdata[1:0] == WIDTH_32 || pwdata[1:0] == WIDTH_64) begin
        st_d.mWidth = pwdata[1:0];
      end
    end
    // widening lifts unfixed fields to the widest
    if (st_q.mWidth == WIDTH_32 && st_d.mWidth == WIDTH_64) begin
      if (HAS_S && !S_FIXED) begin
        sNew = WIDTH_64;
      end
      if (HAS_U && !U_FIXED) begin
        uNew = WIDTH_64;
      end
    end
    // Forced fields follow the machine width
    st_d.sWidth = (BASE64 && HAS_S) ? (S_FIXED ? st_d.mWidth : sNew)
                                    : WIDTH_NONE;
    st_d.uWidth = (BASE64 && HAS_U) ? (U_FIXED ? st_d.mWidth : uNew)
                                    : WIDTH_NONE;
    // trap stacks enable; wins over a same-cycle write
    if (trapTake) begin
      st_d.mpie = st_q.mie;
      st_d.mie = 1'b0;
      st_d.prevPriv = legalPriv(trapFromPriv, st_q.prevPriv);
    end
    // bounded wait, trap when the bound runs out
    if (st_q.wfiBusy) begin
      if (wfiWake) begin
        st_d.wfiBusy = 1'b0;
      end else if (st_q.wfiCount == WFI_LAST) begin
        st_d.wfiBusy = 1'b0;
        st_d.wfiIllegal = 1'b1;
      end else begin
        st_d.wfiCount = st_q.wfiCount + 8'h01;
      end
    end else if (wfiStart && wfiTimed && !wfiWake) begin
      st_d.wfiBusy = 1'b1;
      st_d.wfiCount = '0;
    end
  end

  // Register the whole state; synchronous reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.prevPriv <= RST_PREV;
      st_q.mWidth <= BASE64 ? RST_WIDTH : WIDTH_32;
      st_q.sWidth <= (BASE64 && HAS_S) ? RST_WIDTH : WIDTH_NONE;
      st_q.uWidth <= (BASE64 && HAS_U) ? RST_WIDTH : WIDTH_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Privilege and width for data and execution
  // ****************************************
  // override moves data to previous privilege
  assign dataPriv = st_q.ovr ? st_q.prevPriv : curPriv;

  // Width of a given mode
  function automatic logic [1:0] widthOf(input logic [1:0] p);
    logic [1:0] w;
    unique case (p)
      PRIV_M: w = st_q.mWidth;
      PRIV_S: w = sEff;
      default: w = uEff;
    endcase
    return w;
  endfunction

  // data width follows the data privilege
  // A process, not assigns, so width field writes re-evaluate the lookup
  always_comb begin
    dataWidth = widthOf(dataPriv);
    execWidth = widthOf(curPriv);
  end

  // ignore high source bits, sign-extend results
  width_adjust #(.XW(64)) u_opA (
    .valueIn(srcA), .widthCode(execWidth), .valueOut(opA));
  width_adjust #(.XW(64)) u_opB (
    .valueIn(srcB), .widthCode(execWidth), .valueOut(opB));
  width_adjust #(.XW(64)) u_res (
    .valueIn(rawResult), .widthCode(execWidth), .valueOut(result));
  width_adjust #(.XW(64)) u_addr (
    .valueIn(rawAddr), .widthCode(dataWidth), .valueOut(dataAddr));

  // ****************************************
  // Permission checks and traps
  // ****************************************
  always_comb begin
    pageFault = 1'b0;
    if (pageTranslate) begin
      if (dataLoad && !(pteRead || (st_q.exr && pteExec))) begin
        pageFault = 1'b1;
      end
      // supervisor to user page needs access bit
      if (dataPriv == PRIV_S && pteUser && !st_q.sua) begin
        pageFault = 1'b1;
      end
      if (dataPriv == PRIV_U && !pteUser) begin
        pageFault = 1'b1;
      end
    end
  end

  // physical faults pass untouched by permission bits
  assign accessFault = physFault;

  assign illegalInsn = (curPriv == PRIV_S && st_q.trapVm &&
                        (satpAccess || fenceVma)) ||
                       (curPriv == PRIV_S && st_q.trapRet && sretInsn) ||
                       st_q.wfiIllegal;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Trap taken from an implemented mode
  sequence trapSeq;
    trapTake && (trapFromPriv == PRIV_M ||
                 (trapFromPriv == PRIV_S && HAS_S) ||
                 (trapFromPriv == PRIV_U && HAS_U));
  endsequence

  // Enable cleared and the source mode recorded
  sequence stackedSeq;
    !st_q.mie && st_q.prevPriv == $past(trapFromPriv);
  endsequence

  chk_override_absent: assert property (!HAS_U |-> !st_q.ovr)
    else $error("override set without user mode");
  chk_exr_absent: assert property (!HAS_S |-> !st_q.exr)
    else $error("execute-readable set without supervisor");
  chk_sua_absent: assert property (!HAS_S |-> !st_q.sua)
    else $error("user access set without supervisor");
  chk_vm_trap: assert property ((curPriv == PRIV_S && st_q.trapVm &&
      fenceVma) |-> illegalInsn)
    else $error("fence not trapped");
  chk_return_trap: assert property ((curPriv == PRIV_M && sretInsn &&
      !st_q.wfiIllegal) |-> !illegalInsn)
    else $error("return trapped in machine mode");
  chk_trap_stack: assert property (trapSeq ##0 st_q.mie |=>
      stackedSeq ##0 st_q.mpie)
    else $error("trap did not stack enable");
  chk_wfi_bound: assert property ((wfiStart && wfiTimed && !st_q.wfiBusy
      && !wfiWake) ##1 !wfiWake[*1] |-> ##[0:11] (st_q.wfiIllegal ||
      !st_q.wfiBusy))
    else $error("wait not bounded");
  chk_width_lift: assert property ((wrAccess && paddr == OFF_MWIDTH &&
      st_q.mWidth == WIDTH_32 && pwdata[1:0] == WIDTH_64 && BASE64 &&
      HAS_S && !S_FIXED) |=> st_q.sWidth == WIDTH_64)
    else $error("supervisor width not lifted");
  chk_width_legal: assert property ((BASE64 && HAS_U) |->
      (st_q.uWidth == WIDTH_32 || st_q.uWidth == WIDTH_64))
    else $error("user width illegal");
  chk_data_width: assert property (st_q.ovr |->
      dataWidth == (st_q.prevPriv == PRIV_M ? st_q.mWidth :
                    st_q.prevPriv == PRIV_S ? sEff : uEff))
    else $error("data width not from previous mode");

endmodule // status_privilege_controls
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import status_priv_pkg::*;
;
  // ********
  // Signals
  // ********
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0] curPriv, trapFromPriv, dataPriv, dataWidth, execWidth;
  logic satpAccess, fenceVma, sretInsn, wfiStart, wfiWake, trapTake;
  logic pageTranslate, dataLoad, pteRead, pteExec, pteUser, physFault;
  logic illegalInsn, pageFault, accessFault;
  logic [63:0] srcA, srcB, rawResult, rawAddr, opA, opB, result, dataAddr;
  int errTotal, testsRun, cnt; // Verdict counters and wait length
  // Single control bits at their field positions
  localparam logic [31:0] fMie = 32'h1 << POS_MIE;
  localparam logic [31:0] fMpie = 32'h1 << POS_MPIE;
  localparam logic [31:0] fOvr = 32'h1 << POS_OVR;
  localparam logic [31:0] fExr = 32'h1 << POS_EXR;
  localparam logic [31:0] fSua = 32'h1 << POS_SUA;
  localparam logic [31:0] fTrapVm = 32'h1 << POS_TRAPVM;
  localparam logic [31:0] fWaitTrap = 32'h1 << POS_WAITTRAP;
  localparam logic [31:0] fTrapRet = 32'h1 << POS_TRAPRET;

  // Full build with all lower modes on the wide base
  status_privilege_controls dut (
    .core_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .curPriv, .satpAccess, .fenceVma, .sretInsn,
    .wfiStart, .wfiWake, .trapTake, .trapFromPriv, .pageTranslate,
    .dataLoad, .pteRead, .pteExec, .pteUser, .physFault, .srcA, .srcB,
    .rawResult, .rawAddr, .opA, .opB, .result, .dataAddr, .dataPriv,
    .dataWidth, .execWidth, .illegalInsn, .pageFault, .accessFault
  );

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
  end

  // ********
  // Tasks
  // ********
  // Compare on four-state values so an unknown never matches
  task automatic check(input string nm, input logic [63:0] e,
                       input logic [63:0] s);
    testsRun++;
    if (s !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // One bus transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    er = pslverr;
    // A slave that never answers is a mismatch, not a hang
    if (n >= 20) errTotal++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
                       input string nm);
    logic [31:0] q;
    logic er;
    apb(1'b0, a, 32'h0, q, er);
    check(nm, 64'(e), 64'(q));
  endtask

  // Control word from width fields, previous mode and flag bits
  function automatic logic [31:0] cw(input logic [1:0] sw, uw, pv,
                                     input logic [31:0] fl);
    return fl | (32'(sw) << POS_SW) | (32'(uw) << POS_UW) |
           (32'(pv) << POS_PREV);
  endfunction

  function automatic logic [31:0] c64(input logic [1:0] pv,
                                      input logic [31:0] fl);
    return cw(WIDTH_64, WIDTH_64, pv, fl);
  endfunction

  // Decoded instruction flags in one mode, trap line checked
  task automatic insn(input logic [1:0] p, input logic [2:0] f,
                      input logic e, input string nm);
    @(posedge core_clk);
    curPriv <= p;
    {satpAccess, fenceVma, sretInsn} <= f;
    @(negedge core_clk);
    check(nm, 64'(e), 64'(illegalInsn));
  endtask

  // Load through a page: {translate, read, exec, user, phys}
  task automatic pg(input logic [4:0] v, input logic pf, input string nm);
    @(posedge core_clk);
    {pageTranslate, pteRead, pteExec, pteUser, physFault} <= v;
    dataLoad <= 1'b1;
    @(negedge core_clk);
    check(nm, 64'(pf), 64'(pageFault));
    check({nm, " access"}, 64'(v[0]), 64'(accessFault));
  endtask

  // Issue a wait, optionally wake it; returns cycle of the trap pulse
  task automatic wfi(input int wakeAt, output int seen);
    int n;
    seen = 0;
    @(posedge core_clk);
    wfiStart <= 1'b1;
    @(posedge core_clk);
    wfiStart <= 1'b0;
    for (n = 1; n <= 20; n++) begin
      @(posedge core_clk);
      if (n == wakeAt) wfiWake <= 1'b1;
      @(negedge core_clk);
      if (illegalInsn === 1'b1 && seen == 0) seen = n;
    end
    @(posedge core_clk);
    wfiWake <= 1'b0;
  endtask

  task automatic trap(input logic [1:0] p);
    @(posedge core_clk);
    trapTake <= 1'b1;
    trapFromPriv <= p;
    @(posedge core_clk);
    trapTake <= 1'b0;
  endtask

  task automatic done(input string nm);
    $display("test %s done, mismatches so far %0d", nm, errTotal);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ********
  // Tests
  // ********
  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, satpAccess, fenceVma, sretInsn, wfiStart,
     wfiWake, trapTake, pageTranslate, dataLoad, pteRead, pteExec,
     pteUser, physFault} = '0;
    {paddr, pwdata, trapFromPriv} = '0;
    {srcA, srcB, rawResult, rawAddr} = '0;
    curPriv = PRIV_M;
    errTotal = 0;
    testsRun = 0;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values and an unmapped place
    rdChk(OFF_CTRL, cw(RST_WIDTH, RST_WIDTH, RST_PREV, 0), "ctrl");
    rdChk(OFF_MWIDTH, 32'(WIDTH_64), "mwidth");
    apb(1'b0, 12'h00C, 32'h0, rv, re);
    check("slverr", 64'h1, 64'(re));
    check("unmapped", 64'h0, 64'(rv));
    done("reset");
    // Width fields: mixed, illegal, then widening of the machine
    wr(OFF_CTRL, cw(WIDTH_32, WIDTH_64, PRIV_M, 0));
    rdChk(OFF_CTRL, cw(WIDTH_32, WIDTH_64, PRIV_M, 0), "mixed");
    wr(OFF_CTRL, cw(2'h3, WIDTH_NONE, PRIV_M, 0));
    rdChk(OFF_CTRL, cw(WIDTH_32, WIDTH_64, PRIV_M, 0), "legal");
    wr(OFF_CTRL, cw(WIDTH_32, WIDTH_32, PRIV_M, 0));
    wr(OFF_MWIDTH, 32'(WIDTH_32));
    wr(OFF_MWIDTH, 32'(WIDTH_64));
    rdChk(OFF_CTRL, c64(PRIV_M, 0), "widen");
    done("widths");
    // Narrow user mode: operands cut, results sign-extended
    wr(OFF_CTRL, cw(WIDTH_64, WIDTH_32, PRIV_M, 0));
    @(posedge core_clk);
    curPriv <= PRIV_U;
    srcA <= 64'h1234_5678_8000_0001;
    srcB <= 64'hFFFF_FFFF_7FFF_FFFF;
    rawResult <= 64'h0000_0000_9000_0000;
    rawAddr <= 64'h0000_0001_8000_0000;
    @(negedge core_clk);
    check("execWidth", 64'(WIDTH_32), 64'(execWidth));
    check("opA", 64'hFFFF_FFFF_8000_0001, opA);
    check("opB", 64'h0000_0000_7FFF_FFFF, opB);
    check("result", 64'hFFFF_FFFF_9000_0000, result);
    insn(PRIV_S, 3'b000, 1'b0, "to S");
    check("opA wide", 64'h1234_5678_8000_0001, opA);
    done("operands");
    // Override from machine mode with previous mode user
    insn(PRIV_M, 3'b000, 1'b0, "to M");
    wr(OFF_CTRL, cw(WIDTH_64, WIDTH_32, PRIV_U, fOvr));
    @(negedge core_clk);
    check("dataPriv", 64'(PRIV_U), 64'(dataPriv));
    check("dataWidth", 64'(WIDTH_32), 64'(dataWidth));
    check("dataAddr", 64'hFFFF_FFFF_8000_0000, dataAddr);
    check("fetch width", 64'(WIDTH_64), 64'(execWidth));
    rdChk(OFF_STATE, 32'h4, "state");
    wr(OFF_CTRL, cw(WIDTH_64, WIDTH_32, PRIV_U, 0));
    @(negedge core_clk);
    check("dataPriv off", 64'(PRIV_M), 64'(dataPriv));
    check("dataAddr off", 64'h0000_0001_8000_0000, dataAddr);
    done("override");
    // Page permissions seen from supervisor mode
    insn(PRIV_S, 3'b000, 1'b0, "to S");
    wr(OFF_CTRL, c64(PRIV_M, 0));
    pg(5'b10100, 1'b1, "exec only");
    pg(5'b00100, 1'b0, "no paging");
    pg(5'b11010, 1'b1, "user page");
    pg(5'b11011, 1'b1, "phys");
    wr(OFF_CTRL, c64(PRIV_M, fExr | fSua));
    pg(5'b10100, 1'b0, "exec readable");
    pg(5'b11010, 1'b0, "user access");
    pg(5'b11001, 1'b0, "phys kept");
    insn(PRIV_M, 3'b000, 1'b0, "to M");
    wr(OFF_CTRL, c64(PRIV_S, fOvr));
    pg(5'b11010, 1'b1, "override sup");
    pg(5'b00000, 1'b0, "idle");
    done("pages");
    // Translation control, fence and supervisor return traps
    wr(OFF_CTRL, c64(PRIV_M, fTrapVm | fTrapRet));
    insn(PRIV_S, 3'b100, 1'b1, "satp");
    insn(PRIV_S, 3'b010, 1'b1, "fence");
    insn(PRIV_S, 3'b001, 1'b1, "sret");
    insn(PRIV_M, 3'b111, 1'b0, "machine");
    wr(OFF_CTRL, c64(PRIV_M, 0));
    insn(PRIV_S, 3'b111, 1'b0, "clear");
    insn(PRIV_S, 3'b000, 1'b0, "idle");
    done("traps");
    // Timed wait: timeout, wake, machine, untimed, user
    wr(OFF_CTRL, c64(PRIV_M, fWaitTrap));
    wfi(0, cnt);
    check("timeout", 64'(WFI_CYCLES), 64'(cnt));
    wfi(3, cnt);
    check("woken", 64'h0, 64'(cnt));
    insn(PRIV_M, 3'b000, 1'b0, "to M");
    wfi(0, cnt);
    check("machine wait", 64'h0, 64'(cnt));
    wr(OFF_CTRL, c64(PRIV_M, 0));
    insn(PRIV_S, 3'b000, 1'b0, "to S");
    wfi(0, cnt);
    check("untimed", 64'h0, 64'(cnt));
    insn(PRIV_U, 3'b000, 1'b0, "to U");
    wfi(0, cnt);
    check("user wait", 64'(WFI_CYCLES), 64'(cnt));
    done("wait");
    // Trap entry stacks the enable and records the mode
    wr(OFF_CTRL, c64(PRIV_M, fMie));
    trap(PRIV_S);
    rdChk(OFF_CTRL, c64(PRIV_S, fMpie), "trap S");
    trap(PRIV_U);
    rdChk(OFF_CTRL, c64(PRIV_U, 0), "trap U");
    done("trap");
    final_report();
  end

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(CLK_PERIOD_NS * 5000);
    errTotal++;
    final_report();
  end
endmodule // testbench
`default_nettype wire
